// File: rtl/pwmrdb_core.sv
`timescale 1ns/1ps
`include "pwmrdb_map.svh"

module pwmrdb_core #(
  parameter int DC_W = 7
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shutdown sources and timer.
  input wire logic shutdown_req,
  input wire logic comp_shutdown_req,
  input wire logic comparator_sync_enable,
  input wire logic general_timer_one_tick,
  // PWM waveform and shutdown flag.
  input wire logic pwm_sched,
  output logic pwm_out,
  output logic shutdown_event_flag
);
  logic [7:0] ctrl;
  logic flag;
  logic comp_held;
  logic [DC_W-1:0] dcnt;
  logic [1:0] div;
  logic out_q;
  logic [31:0] rdata_q;
  pwmrdb_pkg::pwmrdb_edge_e st;
  pwmrdb_pkg::pwmrdb_edge_e next_st;

  wire pwm_auto_restart_enable = ctrl[`PWMRDB_RSEN_BIT];
  wire [DC_W-1:0] dead_band_delay_count =
    ctrl[`PWMRDB_DC_MSB:`PWMRDB_DC_LSB];
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == `PWMRDB_CTRL_ADDR;
  wire wr_stat = acc && pwrite && paddr == `PWMRDB_STAT_ADDR;
  wire mapped = paddr == `PWMRDB_CTRL_ADDR ||
                paddr == `PWMRDB_STAT_ADDR;
  wire sw_clear = wr_stat && pwdata[`PWMRDB_STAT_CLR_BIT];
  wire instr_tick = div == `PWMRDB_INSTR_DIV;
  // Comparator shutdown, gated to a timer tick when sync is on.
  wire comp_eff = comparator_sync_enable ? comp_held
                                         : comp_shutdown_req;
  wire src = shutdown_req || comp_eff;
  wire dly_done = dcnt == '0;
  // Gate the output on the live source as well as the flag, so the
  // output drops in the same cycle that the flag rises; waiting for
  // the flag alone would let one active cycle slip into a shutdown.
  wire shut = src || flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_held <= 1'b0;
    end else if (general_timer_one_tick) begin
      comp_held <= comp_shutdown_req;
    end
  end

  // Source presence sets the flag; set wins over clear.
  wire next_flag = src ? 1'b1 :
    (pwm_auto_restart_enable ? 1'b0 :
     (sw_clear ? 1'b0 : flag));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
      ctrl <= `PWMRDB_CTRL_RESET;
    end else begin
      flag <= next_flag;
      if (wr_ctrl) begin
        ctrl <= pwdata[7:0];
      end
    end
  end

  // The divider runs free, so the first instruction tick of a wait
  // may come anywhere from one to four cycles after it starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  // Dead-band sequencer: rising request waits, falling is immediate.
  always_comb begin
    next_st = st;
    unique case (st)
      pwmrdb_pkg::PWMRDB_IDLE:
        if (pwm_sched && !shut) begin
          next_st = (dead_band_delay_count == '0) ?
            pwmrdb_pkg::PWMRDB_ON : pwmrdb_pkg::PWMRDB_WAIT;
        end
      pwmrdb_pkg::PWMRDB_WAIT:
        if (!pwm_sched || shut) begin
          next_st = pwmrdb_pkg::PWMRDB_IDLE;
        end else if (dly_done) begin
          next_st = pwmrdb_pkg::PWMRDB_ON;
        end
      pwmrdb_pkg::PWMRDB_ON:
        if (!pwm_sched || shut) begin
          next_st = pwmrdb_pkg::PWMRDB_IDLE;
        end
      default: next_st = pwmrdb_pkg::PWMRDB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= pwmrdb_pkg::PWMRDB_IDLE;
      dcnt <= '0;
      out_q <= 1'b0;
    end else begin
      st <= next_st;
      out_q <= next_st == pwmrdb_pkg::PWMRDB_ON;
      if (st == pwmrdb_pkg::PWMRDB_IDLE) begin
        dcnt <= dead_band_delay_count;
      end else if (st == pwmrdb_pkg::PWMRDB_WAIT && instr_tick &&
                   !dly_done) begin
        dcnt <= dcnt - DC_W'(1);
      end
    end
  end

  // Read data is registered from the address of the setup cycle, and
  // pready rises at the same edge, so no transfer has a wait state.
  // A master that holds its request until pready is high sees both.
  always_comb begin
    rdata_q = 32'h0000_0000;
    if (paddr == `PWMRDB_CTRL_ADDR) begin
      rdata_q[7:0] = ctrl;
    end else if (paddr == `PWMRDB_STAT_ADDR) begin
      rdata_q[`PWMRDB_STAT_FLAG_BIT] = flag;
      rdata_q[`PWMRDB_STAT_SYNC_BIT] = comp_held;
      rdata_q[`PWMRDB_STAT_OUT_BIT] = out_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !mapped;
      prdata <= rdata_q;
    end
  end

  assign pwm_out = out_q;
  assign shutdown_event_flag = flag;

  // Restart and flag.
  flag_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag && !src && pwm_auto_restart_enable |=> !flag)
    else $error("flag did not self clear");
  restart_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag && !src && pwm_auto_restart_enable && pwm_sched &&
    dead_band_delay_count == '0 ##1 !src && pwm_sched &&
    dead_band_delay_count == '0 |=> pwm_out)
    else $error("output did not restart");
  flag_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag && !pwm_auto_restart_enable && !sw_clear |=> flag)
    else $error("flag cleared without software");
  clr_lose_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sw_clear && src |=> flag)
    else $error("clear beat a live source");
  clr_take_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag && sw_clear && !src |=> !flag)
    else $error("software clear ignored");

  // Shutdown holds the output.
  out_shut_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag |=> !pwm_out)
    else $error("output active during shutdown");
  src_shut_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    src |=> !pwm_out)
    else $error("output active while source present");
  src_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    src |=> flag)
    else $error("flag not set by source");

  // Comparator synchronisation.
  sync_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    comparator_sync_enable && !general_timer_one_tick
    |=> $stable(comp_held))
    else $error("sync comparator changed off tick");
  sync_pass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !comparator_sync_enable && comp_shutdown_req |=> flag)
    else $error("unsynced comparator shutdown late");
  sync_take_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    general_timer_one_tick |=> comp_held == $past(comp_shutdown_req))
    else $error("comparator not captured on tick");

  // Edge timing.
  zero_delay_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st == pwmrdb_pkg::PWMRDB_IDLE && pwm_sched && !shut &&
    dead_band_delay_count == '0 |=> pwm_out)
    else $error("zero count delayed output");
  fall_now_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pwm_sched |=> !pwm_out)
    else $error("inactive edge delayed");
  delay_min_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st == pwmrdb_pkg::PWMRDB_WAIT) |-> !pwm_out[*2])
    else $error("active edge too early");
  cnt_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st == pwmrdb_pkg::PWMRDB_WAIT && $past(st) ==
    pwmrdb_pkg::PWMRDB_WAIT |-> dcnt <= $past(dcnt))
    else $error("delay count rose");
  dcnt_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st == pwmrdb_pkg::PWMRDB_IDLE |=> dcnt == $past(dead_band_delay_count))
    else $error("delay count not loaded");
  dcnt_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st == pwmrdb_pkg::PWMRDB_WAIT && !instr_tick |=> dcnt == $past(dcnt))
    else $error("delay count moved off tick");
  wait_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st != pwmrdb_pkg::PWMRDB_ON |-> !pwm_out)
    else $error("output active before delay end");
  wait_release_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st == pwmrdb_pkg::PWMRDB_WAIT && dly_done && pwm_sched && !shut
    |=> pwm_out)
    else $error("output late after delay end");

  // Helper count of cycles spent waiting, for the bound check below.
  logic [9:0] wait_cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cyc <= 10'h000;
    end else if (st == pwmrdb_pkg::PWMRDB_WAIT) begin
      wait_cyc <= wait_cyc + 10'h001;
    end else begin
      wait_cyc <= 10'h000;
    end
  end
  wait_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wait_cyc <= `PWMRDB_WAIT_MAX)
    else $error("delay wait too long");

  // Register bus.
  pready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held over two cycles");
  slverr_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  ctrl_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl == $past(pwdata[7:0]))
    else $error("control write lost");

  // Main scenarios.
  cv_wait_c: cover property (@(posedge pclk)
    st == pwmrdb_pkg::PWMRDB_WAIT ##1 st == pwmrdb_pkg::PWMRDB_ON);
  cv_restart_c: cover property (@(posedge pclk)
    flag && pwm_auto_restart_enable ##1 !flag);
  cv_swclr_c: cover property (@(posedge pclk)
    flag && sw_clear ##1 !flag);
  cv_sync_c: cover property (@(posedge pclk)
    comparator_sync_enable && general_timer_one_tick &&
    comp_shutdown_req ##1 comp_held ##1 flag);
  cv_zero_c: cover property (@(posedge pclk)
    st == pwmrdb_pkg::PWMRDB_IDLE && pwm_sched && !shut &&
    dead_band_delay_count == '0 ##1 pwm_out);
endmodule

// File: rtl/pwmrdb_map.svh
`ifndef PWMRDB_MAP_SVH
`define PWMRDB_MAP_SVH

// Byte addresses of the APB registers.
`define PWMRDB_CTRL_ADDR 12'h000
`define PWMRDB_STAT_ADDR 12'h004
// Control register layout.
`define PWMRDB_RSEN_BIT 7
`define PWMRDB_DC_MSB 6
`define PWMRDB_DC_LSB 0
`define PWMRDB_CTRL_RESET 8'h00
// Status register layout.
`define PWMRDB_STAT_FLAG_BIT 0
`define PWMRDB_STAT_SYNC_BIT 1
`define PWMRDB_STAT_OUT_BIT 2
`define PWMRDB_STAT_CLR_BIT 0
// Instruction cycle is four system clocks.
`define PWMRDB_INSTR_DIV 2'h3
// Longest wait in cycles: full count of instruction cycles plus slack.
`define PWMRDB_WAIT_MAX 10'h204

`endif

// File: rtl/pwmrdb_pkg.sv
package pwmrdb_pkg;
  typedef enum logic [1:0] {
    PWMRDB_IDLE = 2'b00,
    PWMRDB_WAIT = 2'b01,
    PWMRDB_ON = 2'b10
  } pwmrdb_edge_e;
endpackage

// File: verif/pwmrdb_bridge.sv
`timescale 1ns/1ps
// Bridge switches: a switch driven on while shut down is a fault.
module pwmrdb_bridge (
  // Clock.
  input wire logic pclk,
  // Drive from the block.
  input wire logic pwm_out,
  input wire logic shutdown_event_flag,
  // Fault seen.
  output logic fault
);
  initial fault = 1'b0;
  always @(posedge pclk) begin
    if (pwm_out && shutdown_event_flag) fault <= 1'b1;
  end
endmodule

// File: verif/test_pwm_restart_and_dead_band.sv
`timescale 1ns/1ps
`include "pwmrdb_map.svh"
module test_pwm_restart_and_dead_band;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, err, sd = 0, cs = 0, ce = 0, tk = 0, ps = 0;
  logic pwm_out, flag, fault;
  int err_total = 0, n_compared = 0, cyc = 0, c;
  int tbl[4] = '{0, 1, 5, 127};
  always #25 pclk = ~pclk;
  pwmrdb_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_req(sd), .comp_shutdown_req(cs),
    .comparator_sync_enable(ce), .general_timer_one_tick(tk),
    .pwm_sched(ps), .pwm_out(pwm_out), .shutdown_event_flag(flag));
  pwmrdb_bridge bridge (.pclk(pclk), .pwm_out(pwm_out),
    .shutdown_event_flag(flag), .fault(fault));
  task results;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Setup, then access held until pready; one idle edge keeps psel clean.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task t_regs;
    apb(0, `PWMRDB_CTRL_ADDR, 0); chk(q, 32'h0000_0000);
    apb(1, `PWMRDB_CTRL_ADDR, 32'h0000_0085);
    apb(0, `PWMRDB_CTRL_ADDR, 0); chk(q, 32'h0000_0085);
    apb(0, 12'h008, 0); chk(q, 32'h0000_0000);
    chk(err, 1);
  endtask
  // Rise is counted in edges from the edge that raises the schedule.
  task t_delay(input int n);
    apb(1, `PWMRDB_CTRL_ADDR, n);
    ps <= 1; c = 0;
    do begin @(posedge pclk); c++; end while (pwm_out !== 1'b1 && c < 600);
    if (n == 0) chk(c, 2);
    else chk(c >= 4 * (n - 1) + 2 && c <= 4 * n + 3, 1);
    ps <= 0; wt(2); chk(pwm_out, 0);
  endtask
  task t_auto;
    apb(1, `PWMRDB_CTRL_ADDR, 32'h0000_0080); ps <= 1;
    sd <= 1; wt(4); chk({flag, pwm_out}, 2'b10);
    apb(0, `PWMRDB_STAT_ADDR, 0); chk(q[0], 1);
    sd <= 0; wt(3); chk(flag, 0);
    wt(3); chk(pwm_out, 1);
  endtask
  task t_soft;
    apb(1, `PWMRDB_CTRL_ADDR, 0);
    sd <= 1; wt(2); sd <= 0; wt(10); chk(flag, 1);
    apb(1, `PWMRDB_STAT_ADDR, 1); wt(1); chk(flag, 0);
    wt(3); chk(pwm_out, 1);
  endtask
  task t_sync;
    apb(1, `PWMRDB_CTRL_ADDR, 32'h0000_0080);
    ce <= 1; cs <= 1; wt(8); chk(flag, 0);
    tk <= 1; @(posedge pclk) tk <= 0; wt(3); chk(flag, 1);
    cs <= 0; tk <= 1; @(posedge pclk) tk <= 0; wt(4); chk(flag, 0);
    ce <= 0; ps <= 0;
  endtask
  initial begin
    wt(5); presetn <= 1; @(posedge pclk);
    t_regs;
    foreach (tbl[i]) t_delay(tbl[i]);
    t_auto;
    t_soft;
    t_sync;
    chk(fault, 0);
    results();
  end
endmodule
